// [src/expbi_bridge.sv]
// Purpose: system-side logic of the expansion slot bus
// Assumes: processor strobes are synchronous to i_sys_clk
// Notes:   pin outputs are registered, so each lags its source by one clock; the ready pair lags by two
`timescale 1ns/10ps
module expbi_bridge (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_n,
  input  wire expbi_pkg::expbi_cycle_t i_cycle_kind,
  input  wire logic [19:0]           i_cpu_addr,
  input  wire logic [7:0]            i_cpu_wdata,
  input  wire logic                  i_cpu_ale,
  input  wire logic                  i_cpu_rd,
  input  wire logic                  i_cpu_wr,
  input  wire logic                  i_cpu_den,
  output logic [7:0]                 o_cpu_rdata,
  output logic                       o_cpu_ready,
  input  wire logic                  i_bus_request,
  output logic                       o_bus_grant_ack,
  output logic [11:0]                o_addr_hi,
  output logic [7:0]                 o_muxed_addr_data,
  input  wire logic [7:0]            i_muxed_addr_data,
  output logic                       o_muxed_oe_n,
  output logic                       o_ale,
  output logic                       o_rd_n,
  output logic                       o_wr_n,
  output logic                       o_den_n,
  output logic                       o_io_mem,
  output logic                       o_transfer_direction,
  output logic                       o_status_zero,
  output logic                       o_bus_oe_n,
  input  wire logic                  i_external_wait_ack,
  output logic                       o_ready,
  output logic                       o_slow_phase_clock,
  output logic                       o_slot_select_enable,
  input  wire logic                  i_nmi,
  input  wire logic                  i_instr_end,
  output logic                       o_nmi_take,
  output logic [7:0]                 o_nmi_type,
  input  wire logic                  i_shared_irq_n,
  input  wire logic                  i_parallel_irq_n,
  input  wire logic                  i_serial_adapter_irq_n,
  input  wire logic                  i_expansion_level_four,
  input  wire logic                  i_expansion_level_five,
  input  wire logic                  i_sync_detect_irq,
  input  wire logic                  i_comm_irq,
  input  wire logic                  i_tod_timer_output,
  input  wire logic                  i_keyboard_ready_irq,
  input  wire logic                  i_vertical_sync_irq,
  output logic [7:0]                 o_pic_levels,
  output logic [2:0]                 o_timer_clk,
  output logic [2:0]                 o_timer_gate,
  input  wire logic [1:0]            i_timer_out,
  input  wire logic [1:0]            i_ser_ext_sel,
  input  wire logic [1:0]            i_ser_ext_clk,
  output logic [1:0]                 o_ser_clk,
  output logic                       o_pic_sel,
  output logic                       o_timer_sel,
  input  wire logic                  i_reset_switch,
  output logic                       o_sys_reset
);
  function automatic logic in_span(input logic [19:0] a, input logic [19:0] lo,
                                   input logic [19:0] hi);
    in_span = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [2:0] status_code(input expbi_pkg::expbi_cycle_t k);
    case (k)
      expbi_pkg::EXPBI_FETCH:  status_code = expbi_pkg::ST_FETCH;
      expbi_pkg::EXPBI_MEM_RD: status_code = expbi_pkg::ST_MEM_RD;
      expbi_pkg::EXPBI_MEM_WR: status_code = expbi_pkg::ST_MEM_WR;
      expbi_pkg::EXPBI_INTA:   status_code = expbi_pkg::ST_INTA;
      expbi_pkg::EXPBI_IO_RD:  status_code = expbi_pkg::ST_IO_RD;
      expbi_pkg::EXPBI_IO_WR:  status_code = expbi_pkg::ST_IO_WR;
      expbi_pkg::EXPBI_HALT:   status_code = expbi_pkg::ST_HALT;
      default:                 status_code = expbi_pkg::ST_PASSIVE;
    endcase
  endfunction

  // ---- bus pins: status, strobes, muxed address/data
  logic        grant_r, grant_nxt, ale_r, ale_nxt;
  logic [2:0]  st_r, st_nxt;
  logic [2:0]  strb_r, strb_nxt;
  logic [11:0] ahi_r, ahi_nxt;
  logic [7:0]  mad_r, mad_nxt, rdat_r, rdat_nxt;
  logic        psel_r, psel_nxt, tsel_r, tsel_nxt;

  // address stays on the muxed lines through the edge where latch falls
  always_comb begin
    grant_nxt = i_bus_request;
    st_nxt    = status_code(i_cycle_kind);
    ale_nxt   = i_cpu_ale;
    strb_nxt  = {~i_cpu_den, ~i_cpu_wr, ~i_cpu_rd};
    ahi_nxt   = i_cpu_addr[19:8];
    mad_nxt   = (i_cpu_ale || ale_r) ? i_cpu_addr[7:0] : i_cpu_wdata;
    rdat_nxt  = i_cpu_rd ? i_muxed_addr_data : rdat_r;
    psel_nxt  = (i_cpu_rd || i_cpu_wr) && in_span(i_cpu_addr, expbi_pkg::PIC_LO,
                                                  expbi_pkg::PIC_HI);
    tsel_nxt  = (i_cpu_rd || i_cpu_wr) && in_span(i_cpu_addr, expbi_pkg::TMR_LO,
                                                  expbi_pkg::TMR_HI);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      grant_r <= 1'b0;
      st_r    <= expbi_pkg::ST_PASSIVE;
      ale_r   <= 1'b0;
      strb_r  <= 3'h7;
      ahi_r   <= 12'h000;
      mad_r   <= 8'h00;
      rdat_r  <= 8'h00;
      psel_r  <= 1'b0;
      tsel_r  <= 1'b0;
    end else begin
      grant_r <= grant_nxt;
      st_r    <= st_nxt;
      ale_r   <= ale_nxt;
      strb_r  <= strb_nxt;
      ahi_r   <= ahi_nxt;
      mad_r   <= mad_nxt;
      rdat_r  <= rdat_nxt;
      psel_r  <= psel_nxt;
      tsel_r  <= tsel_nxt;
    end
  end

  assign o_bus_grant_ack      = grant_r;
  assign o_bus_oe_n           = grant_r;
  assign o_muxed_oe_n         = grant_r | ~strb_r[1] ? grant_r : 1'b1; // drive only for writes
  assign {o_io_mem, o_transfer_direction, o_status_zero} = st_r;
  assign o_ale                = ale_r;
  assign {o_den_n, o_wr_n, o_rd_n} = strb_r;
  assign o_addr_hi            = ahi_r;
  assign o_muxed_addr_data    = mad_r;
  assign o_cpu_rdata          = rdat_r;
  assign o_pic_sel            = psel_r;
  assign o_timer_sel          = tsel_r;

  // ---- external acknowledge resync; first stage feeds only the second
  logic wait_s1_r, wait_s2_r;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_s1_r <= 1'b1;
      wait_s2_r <= 1'b1;
    end else begin
      wait_s1_r <= i_external_wait_ack;
      wait_s2_r <= wait_s1_r;
    end
  end
  assign o_cpu_ready = wait_s2_r;
  assign o_ready     = wait_s2_r;

  // ---- non-maskable edge catch; a new edge wins over the take that clears
  logic nmi_prev_r, nmi_prev_nxt, nmi_pend_r, nmi_pend_nxt, nmi_take_r, nmi_take_nxt;
  logic nmi_fall;
  always_comb begin
    nmi_fall     = nmi_prev_r && !i_nmi;
    nmi_prev_nxt = i_nmi;
    nmi_take_nxt = nmi_pend_r && i_instr_end;
    nmi_pend_nxt = nmi_fall || (nmi_pend_r && !nmi_take_nxt);
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nmi_prev_r <= 1'b1;
      nmi_pend_r <= 1'b0;
      nmi_take_r <= 1'b0;
    end else begin
      nmi_prev_r <= nmi_prev_nxt;
      nmi_pend_r <= nmi_pend_nxt;
      nmi_take_r <= nmi_take_nxt;
    end
  end
  assign o_nmi_take = nmi_take_r;
  assign o_nmi_type = expbi_pkg::NMI_TYPE;

  // ---- controller levels; shared request is wired low-active from three sources
  logic [7:0] lvl_r, lvl_nxt;
  logic       rst_out_r;
  always_comb begin
    lvl_nxt = 8'h00;
    lvl_nxt[expbi_pkg::LVL_SYNC] = i_sync_detect_irq;
    lvl_nxt[expbi_pkg::LVL_COMM] = i_comm_irq;
    lvl_nxt[expbi_pkg::LVL_TOD]  = i_tod_timer_output;
    lvl_nxt[expbi_pkg::LVL_PAR]  = !(i_shared_irq_n && i_parallel_irq_n
                                     && i_serial_adapter_irq_n);
    lvl_nxt[expbi_pkg::LVL_EX4]  = i_expansion_level_four;
    lvl_nxt[expbi_pkg::LVL_EX5]  = i_expansion_level_five;
    lvl_nxt[expbi_pkg::LVL_KBD]  = i_keyboard_ready_irq;
    lvl_nxt[expbi_pkg::LVL_VSYN] = i_vertical_sync_irq;
  end
  // reset output comes up set, so power-on is covered without a strap
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lvl_r     <= 8'h00;
      rst_out_r <= 1'b1;
    end else begin
      lvl_r     <= lvl_nxt;
      rst_out_r <= i_reset_switch;
    end
  end
  assign o_pic_levels = lvl_r;
  assign o_sys_reset  = rst_out_r;

  // ---- timer clocks: channels 0,1 serial rate, channel 2 time-of-day rate
  logic [1:0] serclk_r, serclk_nxt;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_tmr
      localparam logic [10:0] HALF = (g == 2) ? expbi_pkg::TOD_HALF : expbi_pkg::SER_HALF;
      logic [10:0] cnt_r, cnt_nxt;
      logic        clk_r, clk_nxt;
      always_comb begin
        cnt_nxt = (cnt_r == HALF - 11'h001) ? 11'h000 : cnt_r + 11'h001;
        clk_nxt = (cnt_r == HALF - 11'h001) ? !clk_r : clk_r;
      end
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          cnt_r <= 11'h000;
          clk_r <= 1'b0;
        end else begin
          cnt_r <= cnt_nxt;
          clk_r <= clk_nxt;
        end
      end
      assign o_timer_clk[g] = clk_r;
    end
  endgenerate

  logic [2:0] gate_r;
  always_comb begin
    serclk_nxt[0] = i_ser_ext_sel[0] ? i_ser_ext_clk[0] : i_timer_out[0];
    serclk_nxt[1] = i_ser_ext_sel[1] ? i_ser_ext_clk[1] : i_timer_out[1];
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      serclk_r <= 2'h0;
      gate_r   <= 3'h7;
    end else begin
      serclk_r <= serclk_nxt;
      gate_r   <= 3'h7;
    end
  end
  assign o_ser_clk    = serclk_r;
  assign o_timer_gate = gate_r;

  // ---- slow phase clock and slot select window
  logic [7:0] ph_cnt_r, ph_cnt_nxt;
  logic       ph_r, ph_nxt, cs_r, cs_nxt, seen_r, seen_nxt, ph_fall, e_acc;
  always_comb begin
    ph_fall    = (ph_cnt_r == expbi_pkg::PH2_HIGH - 8'h01);
    ph_cnt_nxt = (ph_cnt_r == expbi_pkg::PH2_CYC - 8'h01) ? 8'h00 : ph_cnt_r + 8'h01;
    ph_nxt     = (ph_cnt_nxt < expbi_pkg::PH2_HIGH);
    e_acc      = (i_cpu_rd || i_cpu_wr)
                 && in_span(i_cpu_addr, expbi_pkg::SLOT_LO, expbi_pkg::SLOT_HI);
    // a window can change only on a falling phase edge
    cs_nxt     = ph_fall ? (seen_r || e_acc) : cs_r;
    seen_nxt   = ph_fall ? 1'b0 : (seen_r || e_acc);
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_cnt_r <= 8'h00;
      ph_r     <= 1'b1;
      cs_r     <= 1'b0;
      seen_r   <= 1'b0;
    end else begin
      ph_cnt_r <= ph_cnt_nxt;
      ph_r     <= ph_nxt;
      cs_r     <= cs_nxt;
      seen_r   <= seen_nxt;
    end
  end
  assign o_slow_phase_clock   = ph_r;
  assign o_slot_select_enable = cs_r;

  // ---- checks
  sequence s_nmi_edge;
    $fell(i_nmi);
  endsequence
  sequence s_nmi_take;
    i_instr_end ##1 o_nmi_take;
  endsequence
  property p_nmi;
    @(posedge i_sys_clk) disable iff (!i_rst_n) s_nmi_edge ##1 i_instr_end |=> o_nmi_take;
  endproperty
  a_nmi_edge_take: assert property (p_nmi) else $error("nmi edge not taken");
  a_nmi_level_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !nmi_pend_r && !$fell(i_nmi) |=> !o_nmi_take) else $error("nmi take without edge");
  a_status_io_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_cycle_kind == expbi_pkg::EXPBI_IO_WR |=> {o_io_mem, o_transfer_direction, o_status_zero}
    == 3'h6) else $error("io write status wrong");
  a_grant_float: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_bus_grant_ack |-> o_bus_oe_n && o_muxed_oe_n) else $error("bus driven during grant");
  a_level_three: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_shared_irq_n |=> o_pic_levels[3]) else $error("shared request lost");
  a_level_four_five: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ##1 o_pic_levels[5:4] == $past({i_expansion_level_five, i_expansion_level_four}))
    else $error("expansion level mismatch");
  a_reset_switch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_reset_switch |=> o_sys_reset) else $error("reset switch ignored");
  a_wait_resync: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_external_wait_ack ##1 !i_external_wait_ack |=> !o_cpu_ready) else $error("no wait");
  a_ale_addr_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $fell(o_ale) && !o_bus_grant_ack |-> o_muxed_addr_data == $past(i_cpu_addr[7:0], 2))
    else $error("address gone at latch fall");
  a_slot_select_enable_phase: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $changed(o_slot_select_enable) |-> $fell(o_slow_phase_clock))
    else $error("select moved off phase edge");
  a_gate_high: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_timer_gate == 3'h7) else $error("timer gate low");
endmodule

// [src/expbi_pkg.sv]
// Purpose: constants and types for the expansion slot bus interface
// Assumes: 250 MHz system clock, one clock domain
// Notes:   every count is derived from a time or rate printed below
package expbi_pkg;
  typedef enum logic [2:0] {
    EXPBI_FETCH, EXPBI_MEM_RD, EXPBI_MEM_WR, EXPBI_PASSIVE,
    EXPBI_INTA, EXPBI_IO_RD, EXPBI_IO_WR, EXPBI_HALT
  } expbi_cycle_t;

  // status line codes {io_mem, transfer_direction, status_zero}
  localparam logic [2:0] ST_FETCH   = 3'h0;
  localparam logic [2:0] ST_MEM_RD  = 3'h1;
  localparam logic [2:0] ST_MEM_WR  = 3'h2;
  localparam logic [2:0] ST_PASSIVE = 3'h3;
  localparam logic [2:0] ST_INTA    = 3'h4;
  localparam logic [2:0] ST_IO_RD   = 3'h5;
  localparam logic [2:0] ST_IO_WR   = 3'h6;
  localparam logic [2:0] ST_HALT    = 3'h7;

  localparam logic [7:0] NMI_TYPE = 8'h02;

  // address windows
  localparam logic [19:0] PIC_LO   = 20'hE_0000;
  localparam logic [19:0] PIC_HI   = 20'hE_0001;
  localparam logic [19:0] TMR_LO   = 20'hE_0020;
  localparam logic [19:0] TMR_HI   = 20'hE_0023;
  localparam logic [19:0] SLOT_LO  = 20'hE_0000;
  localparam logic [19:0] SLOT_HI  = 20'hE_FFFF;

  // controller level positions
  localparam int LVL_SYNC = 0;
  localparam int LVL_COMM = 1;
  localparam int LVL_TOD  = 2;
  localparam int LVL_PAR  = 3;
  localparam int LVL_EX4  = 4;
  localparam int LVL_EX5  = 5;
  localparam int LVL_KBD  = 6;
  localparam int LVL_VSYN = 7;

  // timing, from rates in kHz and times in ns
  localparam int SYS_CLK_KHZ = 250000;
  localparam int TOD_KHZ     = 100;
  localparam int SER_KHZ     = 1250;
  localparam int PH2_PER_NS  = 1000;
  localparam int CLK_PER_NS  = 4;
  localparam int PH2_HIGH_PC = 40;
  localparam logic [10:0] TOD_HALF = 11'(SYS_CLK_KHZ / (2 * TOD_KHZ));
  localparam logic [10:0] SER_HALF = 11'(SYS_CLK_KHZ / (2 * SER_KHZ));
  localparam logic [7:0]  PH2_CYC  = 8'(PH2_PER_NS / CLK_PER_NS);
  localparam logic [7:0]  PH2_HIGH = 8'(PH2_PER_NS * PH2_HIGH_PC / 100 / CLK_PER_NS);
endpackage

// [dv/expbi_card.sv]
// Purpose: behavioural expansion card on the far side of the slot bus
// Assumes: one clock domain shared with the bridge
// Notes:   released request line reads high because the card drives it high
`timescale 1ns/10ps
module expbi_card (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_irq_on,
  input  wire logic [3:0] i_stretch_len,
  input  wire logic       i_cycle_go,
  input  wire logic       i_hold_req,
  input  wire logic       i_rd_n,
  input  wire logic [7:0] i_rd_byte,
  output logic            o_irq_n,
  output logic            o_wait_ack,
  output logic            o_bus_request,
  output logic [7:0]      o_data
);
  logic [3:0] stretch_r;
  logic [7:0] last_r;

  // open collector model: pulls low when on, and drives the high itself when released
  assign o_irq_n       = i_irq_on ? 1'b0 : 1'b1;
  assign o_bus_request = i_hold_req;
  // data only while read strobe low, else a changing pattern, never the last byte
  assign o_data        = !i_rd_n ? i_rd_byte : ~last_r;

  // acknowledge held low for the commanded number of cycles
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stretch_r <= 4'h0;
      last_r    <= 8'h00;
    end else begin
      last_r <= o_data;
      if (i_cycle_go) begin
        stretch_r <= i_stretch_len;
      end else if (stretch_r != 4'h0) begin
        stretch_r <= stretch_r - 4'h1;
      end
    end
  end
  assign o_wait_ack = (stretch_r == 4'h0);
endmodule

// [dv/expansion_bus_interface_tb.sv]
// Purpose: self-checking bench for the expansion slot bridge
// Assumes: 250 MHz clock, registered pins one cycle behind their source, the ready pair two
// Notes:   expected counts are worked out from rates, not from the design
`timescale 1ns/10ps
module expansion_bus_interface_tb;
  localparam int CLK_KHZ = 250000;
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_cpu_ale = 1'b0, i_cpu_rd = 1'b0;
  logic i_cpu_wr = 1'b0, i_cpu_den = 1'b0, i_nmi = 1'b1, i_instr_end = 1'b0;
  logic i_reset_switch = 1'b0, cycle_go = 1'b0, hold_req = 1'b0;
  expbi_pkg::expbi_cycle_t i_cycle_kind = expbi_pkg::EXPBI_PASSIVE;
  logic [19:0] i_cpu_addr = 20'h0_0000;
  logic [7:0] i_cpu_wdata = 8'h00, rd_byte = 8'h00;
  logic [9:0] irq_v = 10'h000;
  logic [3:0] stretch_len = 4'h0;
  logic [1:0] i_timer_out = 2'h0, i_ser_ext_sel = 2'h0, i_ser_ext_clk = 2'h0;
  logic i_shared_irq_n, i_external_wait_ack, i_bus_request, o_cpu_ready, o_bus_grant_ack;
  logic o_muxed_oe_n, o_ale, o_rd_n, o_wr_n, o_den_n, o_io_mem, o_transfer_direction;
  logic o_status_zero, o_bus_oe_n, o_ready, o_slow_phase_clock, o_slot_select_enable;
  logic o_nmi_take, o_pic_sel, o_timer_sel, o_sys_reset;
  logic [7:0] i_muxed_addr_data, o_cpu_rdata, o_muxed_addr_data, o_nmi_type, o_pic_levels;
  logic [11:0] o_addr_hi;
  logic [2:0] o_timer_clk, o_timer_gate;
  logic [1:0] o_ser_clk;
  int errors = 0, num_checks = 0, nmi_cnt = 0;

  // one source per bit: 0..7 controller levels, 8 parallel, 9 serial adapter
  wire logic i_sync_detect_irq      = irq_v[0];
  wire logic i_comm_irq             = irq_v[1];
  wire logic i_tod_timer_output     = irq_v[2];
  wire logic i_expansion_level_four = irq_v[4];
  wire logic i_expansion_level_five = irq_v[5];
  wire logic i_keyboard_ready_irq   = irq_v[6];
  wire logic i_vertical_sync_irq    = irq_v[7];
  wire logic i_parallel_irq_n       = ~irq_v[8];
  wire logic i_serial_adapter_irq_n = ~irq_v[9];

  expbi_bridge u_expbi_bridge (.i_sys_clk, .i_rst_n, .i_cycle_kind, .i_cpu_addr, .i_cpu_wdata,
    .i_cpu_ale, .i_cpu_rd, .i_cpu_wr, .i_cpu_den, .o_cpu_rdata, .o_cpu_ready, .i_bus_request,
    .o_bus_grant_ack, .o_addr_hi, .o_muxed_addr_data, .i_muxed_addr_data, .o_muxed_oe_n, .o_ale,
    .o_rd_n, .o_wr_n, .o_den_n, .o_io_mem, .o_transfer_direction, .o_status_zero, .o_bus_oe_n,
    .i_external_wait_ack, .o_ready, .o_slow_phase_clock, .o_slot_select_enable, .i_nmi,
    .i_instr_end, .o_nmi_take, .o_nmi_type, .i_shared_irq_n, .i_parallel_irq_n,
    .i_serial_adapter_irq_n, .i_expansion_level_four, .i_expansion_level_five,
    .i_sync_detect_irq, .i_comm_irq, .i_tod_timer_output, .i_keyboard_ready_irq,
    .i_vertical_sync_irq, .o_pic_levels, .o_timer_clk, .o_timer_gate, .i_timer_out,
    .i_ser_ext_sel, .i_ser_ext_clk, .o_ser_clk, .o_pic_sel, .o_timer_sel, .i_reset_switch,
    .o_sys_reset);

  expbi_card u_expbi_card (.i_sys_clk, .i_rst_n, .i_irq_on(irq_v[3]), .i_stretch_len(stretch_len),
    .i_cycle_go(cycle_go), .i_hold_req(hold_req), .i_rd_n(o_rd_n), .i_rd_byte(rd_byte),
    .o_irq_n(i_shared_irq_n), .o_wait_ack(i_external_wait_ack), .o_bus_request(i_bus_request),
    .o_data(i_muxed_addr_data));

  // clock and a counter of taken non-maskable requests
  always #2 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (o_nmi_take === 1'b1) nmi_cnt <= nmi_cnt + 1;

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return o_timer_clk[0];
      1: return o_timer_clk[1];
      2: return o_timer_clk[2];
      3: return o_slow_phase_clock;
      default: return o_slot_select_enable;
    endcase
  endfunction

  // length of the next complete high phase, bounded so a stuck line cannot hang
  task automatic high_len(input int s, output int n);
    int w;
    w = 0;
    n = 0;
    while (pick(s) !== 1'b0 && w < 3000) begin
      cyc(1);
      w++;
    end
    while (pick(s) !== 1'b1 && w < 3000) begin
      cyc(1);
      w++;
    end
    while (pick(s) === 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic t_status;
    for (int k = 0; k < 8; k++) begin
      @(posedge i_sys_clk) i_cycle_kind <= expbi_pkg::expbi_cycle_t'(k);
      cyc(1);
      chk({o_io_mem, o_transfer_direction, o_status_zero}, 20'(k));
    end
  endtask

  // two falls while not at instruction end merge into one take
  task automatic t_nmi;
    int n0;
    n0 = nmi_cnt;
    for (int k = 0; k < 4; k++) @(posedge i_sys_clk) i_nmi <= k[0];
    cyc(4);
    chk(20'(nmi_cnt - n0), 20'h0_0000);
    @(posedge i_sys_clk) i_instr_end <= 1'b1;
    cyc(8);
    chk(20'(nmi_cnt - n0), 20'h0_0001);
    chk(o_nmi_type, 20'h0_0002);
    @(posedge i_sys_clk) i_nmi <= 1'b1;
    i_instr_end <= 1'b0;
  endtask

  task automatic t_levels;
    for (int i = 0; i < 10; i++) begin
      @(posedge i_sys_clk) irq_v <= 10'h001 << i;
      cyc(2);
      chk(o_pic_levels, (i < 8) ? 20'(1 << i) : 20'h0_0008);
    end
    @(posedge i_sys_clk) irq_v <= 10'h000;
  endtask

  task automatic t_reset_sw;
    @(posedge i_sys_clk) i_reset_switch <= 1'b1;
    cyc(2);
    chk(o_sys_reset, 20'h0_0001);
    @(posedge i_sys_clk) i_reset_switch <= 1'b0;
    cyc(2);
    chk(o_sys_reset, 20'h0_0000);
  endtask

  task automatic t_timers;
    int n;
    chk(o_timer_gate, 20'h0_0007);
    for (int s = 0; s < 2; s++) begin
      high_len(s, n);
      chk(20'(n), 20'(CLK_KHZ / (2 * 1250)));
    end
    high_len(2, n);
    chk(20'(n), 20'(CLK_KHZ / (2 * 100)));
    @(posedge i_sys_clk) i_timer_out <= 2'b11;
    i_ser_ext_sel <= 2'b10;
    i_ser_ext_clk <= 2'b01;
    cyc(2);
    chk(o_ser_clk, 20'h0_0001);
  endtask

  task automatic t_grant;
    @(posedge i_sys_clk) hold_req <= 1'b1;
    i_cpu_wr <= 1'b1;
    cyc(3);
    chk({o_bus_grant_ack, o_bus_oe_n, o_muxed_oe_n}, 20'h0_0007);
    @(posedge i_sys_clk) hold_req <= 1'b0;
    cyc(3);
    chk({o_bus_grant_ack, o_bus_oe_n, o_muxed_oe_n}, 20'h0_0000);
    @(posedge i_sys_clk) i_cpu_wr <= 1'b0;
  endtask

  task automatic t_wait;
    int n;
    n = 0;
    @(posedge i_sys_clk) stretch_len <= 4'h3;
    cycle_go <= 1'b1;
    @(posedge i_sys_clk) cycle_go <= 1'b0;
    for (int k = 0; k < 12; k++) begin
      cyc(1);
      if (o_cpu_ready === 1'b0 && o_ready === 1'b0) n++;
    end
    chk(20'(n), 20'h0_0003);
  endtask

  // address phase, write phase, then a read answered by the card
  task automatic t_walk;
    @(posedge i_sys_clk) i_cpu_ale <= 1'b1;
    i_cpu_addr <= 20'h5_A3C6;
    i_cpu_wdata <= 8'h69;
    @(posedge i_sys_clk) i_cpu_ale <= 1'b0;
    #1;
    chk(20'(o_ale), 20'h0_0001);
    chk({o_addr_hi, o_muxed_addr_data}, 20'h5_A3C6);
    @(posedge i_sys_clk) i_cpu_wr <= 1'b1;
    i_cpu_den <= 1'b1;
    #1;
    chk({o_ale, o_muxed_addr_data}, 20'h0_00C6);
    cyc(1);
    chk({o_wr_n, o_den_n, o_muxed_oe_n, o_muxed_addr_data}, 20'h0_0069);
    @(posedge i_sys_clk) i_cpu_wr <= 1'b0;
    i_cpu_den <= 1'b0;
    i_cpu_rd <= 1'b1;
    rd_byte <= 8'hA5;
    cyc(3);
    @(posedge i_sys_clk) i_cpu_rd <= 1'b0;
    cyc(2);
    chk(o_cpu_rdata, 20'h0_00A5);
  endtask

  task automatic t_slot;
    int n;
    @(posedge i_sys_clk) i_cpu_addr <= 20'hE_0001;
    i_cpu_rd <= 1'b1;
    @(posedge i_sys_clk) i_cpu_addr <= 20'hE_0022;
    #1;
    chk({o_pic_sel, o_timer_sel}, 20'h0_0002);
    @(posedge i_sys_clk) i_cpu_rd <= 1'b0;
    #1;
    chk({o_pic_sel, o_timer_sel}, 20'h0_0001);
    high_len(4, n);
    chk(20'(n), 20'(1000 / 4));
    high_len(3, n);
    chk(20'(n), 20'(1000 * 40 / 100 / 4));
    @(posedge i_sys_clk) i_cpu_addr <= 20'hD_FFFF;
    i_cpu_wr <= 1'b1;
    @(posedge i_sys_clk) i_cpu_wr <= 1'b0;
    n = 0;
    for (int k = 0; k < 600; k++) begin
      cyc(1);
      if (o_slot_select_enable !== 1'b0) n++;
    end
    chk(20'(n), 20'h0_0000);
  endtask

  // watchdog sized well past the longest timer measurement
  initial begin
    repeat (40000) @(posedge i_sys_clk);
    errors++;
    end_of_test();
  end

  initial begin
    cyc(3);
    chk(o_sys_reset, 20'h0_0001);
    @(posedge i_sys_clk) i_rst_n <= 1'b1;
    t_status();
    t_nmi();
    t_levels();
    t_reset_sw();
    t_timers();
    t_grant();
    t_wait();
    t_walk();
    t_slot();
    end_of_test();
  end
endmodule
